// ### ptm_timer.sv
`timescale 1ns/1ps
`include "ptm_map.svh"

// Contract
// - flag register: match flags 0-3 in bits 0-3, capture flag bit 4, reset zero.
// - a flag goes high on its event and stays high until software clears it.
// - writing one clears a flag, writing zero leaves it unchanged.
// - control bit 0 lets both counters count; when clear both hold.
// - control bit 1 holds both counters at zero from the next edge.
// - timer counter is 16 bits and steps when prescale counter hits terminal count.
// - timer counter wraps from ffff to zero without raising any flag.
// - a 16-bit prescale limit sets the highest prescale counter value.
// - prescale counter counts each enabled clock, returns to zero after the limit.
// - limit zero steps timer every clock, limit one every two clocks.
// - match 0 with action bit 0 raises match flag 0.
// - match 0 with action bit 1 resets the timer counter.
// - match 0 with action bit 2 stops counters and clears control bit 0.
// - match 1 with action bit 3 raises match flag 1.
// - channels 1-3 have reset/stop bits 4,5,7,8,10,11 and irq bits 6,9.
// - every match value is compared continuously with the timer counter.
module ptm_timer #(
    parameter int CNT_W     = 16,
    parameter int NUM_MATCH = 4
) (
    input  logic                aclk,
    input  logic                aresetn,
    input  logic                awvalid,
    output logic                awready,
    input  ptm_pkg::ptm_word_t  awaddr,
    input  logic                wvalid,
    output logic                wready,
    input  ptm_pkg::ptm_word_t  wdata,
    input  ptm_pkg::ptm_strb_t  wstrb,
    output logic                bvalid,
    input  logic                bready,
    output logic [1:0]          bresp,
    input  logic                arvalid,
    output logic                arready,
    input  ptm_pkg::ptm_word_t  araddr,
    output logic                rvalid,
    input  logic                rready,
    output ptm_pkg::ptm_word_t  rdata,
    output logic [1:0]          rresp,
    input  logic                capture_event,
    output logic                irq
);

    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("ptm_timer: CNT_W must lie in 2..32");
    end
    if (NUM_MATCH < 1 || NUM_MATCH > `PTM_MAX_MATCH) begin : g_bad_match
        $error("ptm_timer: NUM_MATCH must lie in 1..4");
    end

    function automatic ptm_pkg::ptm_word_t strb_mask(input ptm_pkg::ptm_strb_t s);
        ptm_pkg::ptm_word_t m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{s[b]}};
        end
        return m;
    endfunction

    function automatic ptm_pkg::ptm_word_t merge(input ptm_pkg::ptm_word_t old_v,
                                                 input ptm_pkg::ptm_word_t new_v,
                                                 input ptm_pkg::ptm_word_t m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic is_mapped(input ptm_pkg::ptm_word_t a);
        logic hit;
        hit = (a == `PTM_ADDR_EVENT_FLAGS) || (a == `PTM_ADDR_TIMER_CONTROL) ||
              (a == `PTM_ADDR_TIMER_COUNT) || (a == `PTM_ADDR_PRESCALE_LIMIT) ||
              (a == `PTM_ADDR_PRESCALE_COUNT) || (a == `PTM_ADDR_MATCH_ACTION) ||
              (a == `PTM_ADDR_CAPTURE_CONTROL) || (a == `PTM_ADDR_IRQ_MASK) ||
              (a == `PTM_ADDR_IRQ_STATUS);
        for (int i = 0; i < NUM_MATCH; i++) begin
            if (a == `PTM_ADDR_MATCH_VALUE0 + 32'(i) * `PTM_ADDR_MATCH_STEP) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // register file
    logic [CNT_W-1:0]           main_count_reg;
    logic [CNT_W-1:0]           main_count_next;
    logic [CNT_W-1:0]           prescale_count_value_reg;
    logic [CNT_W-1:0]           prescale_count_value_next;
    logic [CNT_W-1:0]           prescale_limit_value_reg;
    logic [CNT_W-1:0]           match_value_reg [NUM_MATCH];
    logic [`PTM_CTRL_W-1:0]     counter_control_reg;
    logic [`PTM_CTRL_W-1:0]     counter_control_next;
    logic [`PTM_MCR_W-1:0]      match_action_reg;
    logic [`PTM_FLAG_W-1:0]     event_flag_reg;
    logic [`PTM_FLAG_W-1:0]     event_flag_next;
    logic [`PTM_FLAG_W-1:0]     irq_mask_reg;
    logic [`PTM_FLAG_W-1:0]     irq_status_reg;
    logic [`PTM_FLAG_W-1:0]     irq_status_next;
    logic                       capture_control_reg;

    // bus channel state
    logic                       aw_have_reg;
    logic                       aw_have_next;
    ptm_pkg::ptm_word_t         aw_addr_reg;
    logic                       w_have_reg;
    logic                       w_have_next;
    ptm_pkg::ptm_word_t         w_data_reg;
    ptm_pkg::ptm_strb_t         w_strb_reg;
    logic                       awready_reg;
    logic                       wready_reg;
    logic                       bvalid_reg;
    logic                       bvalid_next;
    logic [1:0]                 bresp_reg;
    logic                       arready_reg;
    logic                       rvalid_reg;
    logic                       rvalid_next;
    ptm_pkg::ptm_word_t         rdata_reg;
    ptm_pkg::ptm_word_t         rdata_mux;
    logic [1:0]                 rresp_reg;
    logic                       irq_reg;

    logic                       aw_fire;
    logic                       w_fire;
    logic                       ar_fire;
    logic                       do_write;
    ptm_pkg::ptm_word_t         wmask;
    ptm_pkg::ptm_word_t         flag_clr;
    logic                       tc_wr;
    logic                       pc_wr;
    logic                       ctrl_wr;
    logic [NUM_MATCH-1:0]       mr_wr;
    logic                       status_rd_clr;

    // match and counting
    logic [NUM_MATCH-1:0]       hit;
    logic [NUM_MATCH-1:0]       hit_q_reg;
    logic [NUM_MATCH-1:0]       evt;
    logic [NUM_MATCH-1:0]       irq_en;
    logic [NUM_MATCH-1:0]       rst_en;
    logic [NUM_MATCH-1:0]       stop_en;
    logic                       any_rst;
    logic                       any_stop;
    logic                       cnt_en;
    logic                       cnt_rst;
    logic                       tick;
    logic [`PTM_FLAG_W-1:0]     flag_set;

    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;
    assign irq     = irq_reg;

    // write channel: address and data accepted in either order
    assign aw_fire  = awvalid & awready_reg;
    assign w_fire   = wvalid & wready_reg;
    assign do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign wmask    = strb_mask(w_strb_reg);
    assign flag_clr = w_data_reg & wmask;

    always_comb begin
        aw_have_next = (aw_have_reg | aw_fire) & ~do_write;
        w_have_next  = (w_have_reg | w_fire) & ~do_write;
        bvalid_next  = do_write | (bvalid_reg & ~bready);
    end

    always_comb begin
        tc_wr   = do_write && (aw_addr_reg == `PTM_ADDR_TIMER_COUNT);
        pc_wr   = do_write && (aw_addr_reg == `PTM_ADDR_PRESCALE_COUNT);
        ctrl_wr = do_write && (aw_addr_reg == `PTM_ADDR_TIMER_CONTROL);
        for (int i = 0; i < NUM_MATCH; i++) begin
            mr_wr[i] = do_write && (aw_addr_reg ==
                       `PTM_ADDR_MATCH_VALUE0 + 32'(i) * `PTM_ADDR_MATCH_STEP);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= ptm_pkg::PTM_RESP_OKAY;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awready_reg <= ~aw_have_next & ~bvalid_next;
            wready_reg  <= ~w_have_next & ~bvalid_next;
            bvalid_reg  <= bvalid_next;
            if (do_write) begin
                bresp_reg <= is_mapped(aw_addr_reg) ? ptm_pkg::PTM_RESP_OKAY
                                                    : ptm_pkg::PTM_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            if (aw_fire) begin
                aw_addr_reg <= awaddr;
            end
            if (w_fire) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
        end
    end

    // read channel: data registered one cycle after the address is taken
    assign ar_fire       = arvalid & arready_reg;
    assign status_rd_clr = ar_fire && (araddr == `PTM_ADDR_IRQ_STATUS);
    assign rvalid_next   = ar_fire | (rvalid_reg & ~rready);

    always_comb begin
        rdata_mux = '0;
        unique case (araddr)
            `PTM_ADDR_EVENT_FLAGS:     rdata_mux = 32'(event_flag_reg);
            `PTM_ADDR_TIMER_CONTROL:   rdata_mux = 32'(counter_control_reg);
            `PTM_ADDR_TIMER_COUNT:     rdata_mux = 32'(main_count_reg);
            `PTM_ADDR_PRESCALE_LIMIT:  rdata_mux = 32'(prescale_limit_value_reg);
            `PTM_ADDR_PRESCALE_COUNT:  rdata_mux = 32'(prescale_count_value_reg);
            `PTM_ADDR_MATCH_ACTION:    rdata_mux = 32'(match_action_reg);
            `PTM_ADDR_CAPTURE_CONTROL: rdata_mux = 32'(capture_control_reg);
            `PTM_ADDR_IRQ_MASK:        rdata_mux = 32'(irq_mask_reg);
            `PTM_ADDR_IRQ_STATUS:      rdata_mux = 32'(irq_status_reg);
            default: begin
                for (int i = 0; i < NUM_MATCH; i++) begin
                    if (araddr == `PTM_ADDR_MATCH_VALUE0 + 32'(i) * `PTM_ADDR_MATCH_STEP) begin
                        rdata_mux = 32'(match_value_reg[i]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= ptm_pkg::PTM_RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
            if (ar_fire) begin
                rdata_reg <= rdata_mux;
                rresp_reg <= is_mapped(araddr) ? ptm_pkg::PTM_RESP_OKAY
                                               : ptm_pkg::PTM_RESP_SLVERR;
            end
        end
    end

    // match compare and action decode
    always_comb begin
        for (int i = 0; i < NUM_MATCH; i++) begin
            hit[i]     = (main_count_reg == match_value_reg[i]);
            irq_en[i]  = match_action_reg[i*`PTM_MCR_STRIDE + `PTM_MCR_IRQ_OFS];
            rst_en[i]  = match_action_reg[i*`PTM_MCR_STRIDE + `PTM_MCR_RESET_OFS];
            stop_en[i] = match_action_reg[i*`PTM_MCR_STRIDE + `PTM_MCR_STOP_OFS];
        end
    end

    // action fires when equality newly appears
    assign evt      = hit & ~hit_q_reg;
    assign any_rst  = |(evt & rst_en);
    assign any_stop = |(evt & stop_en);
    assign cnt_en   = counter_control_reg[`PTM_CTRL_ENABLE_BIT];
    assign cnt_rst  = counter_control_reg[`PTM_CTRL_RESET_BIT];
    assign tick     = cnt_en & ~any_stop & (prescale_count_value_reg == prescale_limit_value_reg);

    // counters and match values all reset to zero, so every channel starts equal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_q_reg <= '1;
        end else begin
            hit_q_reg <= hit;
        end
    end

    always_comb begin
        main_count_next = main_count_reg;
        if (cnt_rst) begin
            main_count_next = '0;
        end else if (tc_wr) begin
            main_count_next = CNT_W'(merge(32'(main_count_reg), w_data_reg, wmask));
        end else if (any_rst) begin
            main_count_next = '0;
        end else if (tick) begin
            main_count_next = CNT_W'(main_count_reg + 1'b1);
        end
    end

    always_comb begin
        prescale_count_value_next = prescale_count_value_reg;
        if (cnt_rst) begin
            prescale_count_value_next = '0;
        end else if (pc_wr) begin
            prescale_count_value_next =
                CNT_W'(merge(32'(prescale_count_value_reg), w_data_reg, wmask));
        end else if (any_rst) begin
            prescale_count_value_next = '0;
        end else if (cnt_en && !any_stop) begin
            prescale_count_value_next = tick ? '0
                                      : CNT_W'(prescale_count_value_reg + 1'b1);
        end
    end

    always_comb begin
        counter_control_next = counter_control_reg;
        if (ctrl_wr) begin
            counter_control_next =
                `PTM_CTRL_W'(merge(32'(counter_control_reg), w_data_reg, wmask));
        end
        if (any_stop) begin
            counter_control_next[`PTM_CTRL_ENABLE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_count_reg           <= '0;
            prescale_count_value_reg <= '0;
            counter_control_reg      <= `PTM_RST_CTRL;
        end else begin
            main_count_reg           <= main_count_next;
            prescale_count_value_reg <= prescale_count_value_next;
            counter_control_reg      <= counter_control_next;
        end
    end

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_limit_value_reg <= '0;
            match_action_reg         <= `PTM_RST_MCR;
            capture_control_reg      <= 1'b0;
            irq_mask_reg             <= `PTM_RST_FLAGS;
            for (int i = 0; i < NUM_MATCH; i++) begin
                match_value_reg[i] <= '0;
            end
        end else if (do_write) begin
            unique case (aw_addr_reg)
                `PTM_ADDR_PRESCALE_LIMIT: prescale_limit_value_reg <=
                    CNT_W'(merge(32'(prescale_limit_value_reg), w_data_reg, wmask));
                `PTM_ADDR_MATCH_ACTION: match_action_reg <=
                    `PTM_MCR_W'(merge(32'(match_action_reg), w_data_reg, wmask));
                `PTM_ADDR_CAPTURE_CONTROL: capture_control_reg <=
                    wmask[`PTM_CAP_IRQ_EN_BIT] ? w_data_reg[`PTM_CAP_IRQ_EN_BIT]
                                               : capture_control_reg;
                `PTM_ADDR_IRQ_MASK: irq_mask_reg <=
                    `PTM_FLAG_W'(merge(32'(irq_mask_reg), w_data_reg, wmask));
                default: begin
                    for (int i = 0; i < NUM_MATCH; i++) begin
                        if (mr_wr[i]) begin
                            match_value_reg[i] <=
                                CNT_W'(merge(32'(match_value_reg[i]), w_data_reg, wmask));
                        end
                    end
                end
            endcase
        end
    end

    // event flags, interrupt status and interrupt line
    always_comb begin
        flag_set = '0;
        for (int i = 0; i < NUM_MATCH; i++) begin
            flag_set[i] = evt[i] & irq_en[i];
        end
        flag_set[`PTM_FLAG_CAPTURE_BIT] = capture_event & capture_control_reg;
    end

    always_comb begin
        event_flag_next = event_flag_reg;
        if (do_write && aw_addr_reg == `PTM_ADDR_EVENT_FLAGS) begin
            event_flag_next = event_flag_reg & ~flag_clr[`PTM_FLAG_W-1:0];
        end
        event_flag_next = event_flag_next | flag_set;
        irq_status_next = (status_rd_clr ? `PTM_RST_FLAGS : irq_status_reg) | flag_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_flag_reg <= `PTM_RST_FLAGS;
            irq_status_reg <= `PTM_RST_FLAGS;
            irq_reg        <= 1'b0;
        end else begin
            event_flag_reg <= event_flag_next;
            irq_status_reg <= irq_status_next;
            irq_reg        <= |(irq_status_next & irq_mask_reg);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_COUNT_RESET_BIT_CLEARS: assert property (cnt_rst |=> main_count_reg == '0 &&
        prescale_count_value_reg == '0) else $error("counter reset did not clear counters");
    AST_DISABLED_HOLDS: assert property (!cnt_en && !cnt_rst && !tc_wr && !pc_wr &&
        !any_rst |=> $stable(main_count_reg) && $stable(prescale_count_value_reg))
        else $error("disabled counters moved");
    AST_TERMINAL_STEP: assert property (tick && !cnt_rst && !tc_wr && !pc_wr &&
        !any_rst |=> prescale_count_value_reg == '0 &&
        main_count_reg == CNT_W'($past(main_count_reg) + 1'b1))
        else $error("terminal count did not step timer");
    AST_PRESCALE_COUNTS: assert property (cnt_en && !any_stop && !tick && !cnt_rst &&
        !pc_wr && !tc_wr && !any_rst |=> $stable(main_count_reg) &&
        prescale_count_value_reg == CNT_W'($past(prescale_count_value_reg) + 1'b1))
        else $error("prescale counter did not increment");
    AST_WRAP_QUIET: assert property (tick && main_count_reg == '1 && !cnt_rst &&
        !tc_wr && !any_rst && flag_set == '0 && !(do_write &&
        aw_addr_reg == `PTM_ADDR_EVENT_FLAGS) |=> main_count_reg == '0 &&
        $stable(event_flag_reg)) else $error("wrap misbehaved");
    AST_FLAG_STICKY: assert property (do_write == 1'b0 |=>
        (event_flag_reg & $past(event_flag_reg)) == $past(event_flag_reg))
        else $error("event flag dropped without a write");
    AST_W1C: assert property (do_write && aw_addr_reg == `PTM_ADDR_EVENT_FLAGS &&
        flag_set == '0 |=> event_flag_reg ==
        ($past(event_flag_reg) & ~$past(flag_clr[`PTM_FLAG_W-1:0])))
        else $error("write-one-to-clear wrong");
    AST_MATCH_FLAG: assert property (|(evt & irq_en) |=>
        (event_flag_reg[NUM_MATCH-1:0] & $past(evt & irq_en)) == $past(evt & irq_en))
        else $error("match flag not raised");
    AST_MATCH_RESET: assert property (any_rst && !cnt_rst && !tc_wr |=>
        main_count_reg == '0) else $error("reset on match missed");
    AST_MATCH_STOP: assert property (any_stop |=> !cnt_en ##1
        (cnt_rst || tc_wr || pc_wr || ctrl_wr || any_rst || $stable(prescale_count_value_reg)))
        else $error("stop on match missed");
    AST_CAPTURE_FLAG: assert property (capture_event && capture_control_reg |=>
        event_flag_reg[`PTM_FLAG_CAPTURE_BIT]) else $error("capture flag not raised");
    AST_IRQ_LINE: assert property (irq_reg == |(irq_status_reg & $past(irq_mask_reg)) ||
        $past(do_write)) else $error("interrupt line disagrees with status");

    COV_MATCH_FLAG: cover property (|(evt & irq_en) ##1 event_flag_reg != '0);
    COV_STOP: cover property (any_stop ##1 !cnt_en);
    COV_WRAP: cover property (tick && main_count_reg == '1);
    COV_RESET_AND_STOP: cover property (any_rst && any_stop);

endmodule

// ### ptm_map.svh
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// register byte addresses
`define PTM_ADDR_EVENT_FLAGS     32'h4000c000
`define PTM_ADDR_TIMER_CONTROL   32'h4000c004
`define PTM_ADDR_TIMER_COUNT     32'h4000c008
`define PTM_ADDR_PRESCALE_LIMIT  32'h4000c00c
`define PTM_ADDR_PRESCALE_COUNT  32'h4000c010
`define PTM_ADDR_MATCH_ACTION    32'h4000c014
`define PTM_ADDR_MATCH_VALUE0    32'h4000c018
`define PTM_ADDR_MATCH_STEP      32'h00000004
`define PTM_ADDR_CAPTURE_CONTROL 32'h4000c028
`define PTM_ADDR_IRQ_MASK        32'h4000c040
`define PTM_ADDR_IRQ_STATUS      32'h4000c044

// field widths and positions
`define PTM_CTRL_W               2
`define PTM_CTRL_ENABLE_BIT      0
`define PTM_CTRL_RESET_BIT       1
`define PTM_MCR_W                12
`define PTM_MCR_STRIDE           3
`define PTM_MCR_IRQ_OFS          0
`define PTM_MCR_RESET_OFS        1
`define PTM_MCR_STOP_OFS         2
`define PTM_FLAG_W               5
`define PTM_FLAG_CAPTURE_BIT     4
`define PTM_MAX_MATCH            4
`define PTM_CAP_IRQ_EN_BIT       0

// reset values
`define PTM_RST_CTRL             2'h0
`define PTM_RST_MCR              12'h000
`define PTM_RST_FLAGS            5'h00

`endif

// ### ptm_pkg.sv
package ptm_pkg;

    typedef logic [31:0] ptm_word_t;
    typedef logic [3:0]  ptm_strb_t;

    typedef enum logic [1:0] {
        PTM_RESP_OKAY   = 2'h0,
        PTM_RESP_SLVERR = 2'h2
    } ptm_resp_e;

endpackage

// ### ptm_timer_tb.sv
`timescale 1ns/1ps
`include "ptm_map.svh"
module testbench;
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0, capture_event = 1'b0;
    ptm_pkg::ptm_word_t awaddr = '0, wdata = '0, araddr = '0, rdata, rv;
    ptm_pkg::ptm_strb_t wstrb = 4'hf;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]         bresp, rresp, wr_r, rd_r;
    int                 miscompares = 0;
    int                 tests_run = 0;

    ptm_timer u_ptm_timer (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .capture_event(capture_event),
        .irq(irq));

    always #10 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            wr_r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        logic ta, tv;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(negedge aclk);
            ta = arvalid & arready;
            tv = rvalid;
            rv = rdata;
            rd_r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tv) break;
        end
        rready <= 1'b0;
    endtask

    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, rv, e);
    endtask

    task automatic pulse_capture();
        @(posedge aclk);
        capture_event <= 1'b1;
        @(posedge aclk);
        capture_event <= 1'b0;
    endtask

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) rc("reset_value", `PTM_ADDR_EVENT_FLAGS + 4 * i, 0);
        chk("mapped_rresp", 32'(rd_r), 0);
        rc("unmapped_rdata", 32'h4000c030, 0);
        chk("unmapped_rresp", 32'(rd_r), 32'h2);
        wr(32'h4000c030, 32'h1);
        chk("unmapped_bresp", 32'(wr_r), 32'h2);
        // irq, reset and stop on channel 0 together
        wr(`PTM_ADDR_PRESCALE_LIMIT, 32'h1);
        chk("mapped_bresp", 32'(wr_r), 0);
        wr(`PTM_ADDR_MATCH_VALUE0, 32'h3);
        wr(`PTM_ADDR_MATCH_ACTION, 32'h7);
        wr(`PTM_ADDR_TIMER_CONTROL, 32'h1);
        repeat (40) @(posedge aclk);
        rc("ctrl_after_stop", `PTM_ADDR_TIMER_CONTROL, 0);
        rc("count_after_reset", `PTM_ADDR_TIMER_COUNT, 0);
        rc("flags_match0", `PTM_ADDR_EVENT_FLAGS, 32'h1);
        chk("irq_masked", 32'(irq), 0);
        wr(`PTM_ADDR_IRQ_MASK, 32'h1f);
        repeat (2) @(posedge aclk);
        chk("irq_unmasked", 32'(irq), 32'h1);
        rc("irq_status", `PTM_ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq_cleared", 32'(irq), 0);
        wr(`PTM_ADDR_EVENT_FLAGS, 32'h0);
        rc("flags_w0", `PTM_ADDR_EVENT_FLAGS, 32'h1);
        wr(`PTM_ADDR_EVENT_FLAGS, 32'h1);
        rc("flags_w1", `PTM_ADDR_EVENT_FLAGS, 0);
        // hold of the timer counter and synchronous clear of both counters
        wr(`PTM_ADDR_TIMER_COUNT, 32'h5);
        repeat (10) @(posedge aclk);
        rc("count_held", `PTM_ADDR_TIMER_COUNT, 32'h5);
        wr(`PTM_ADDR_TIMER_CONTROL, 32'h3);
        repeat (10) @(posedge aclk);
        rc("count_in_reset", `PTM_ADDR_TIMER_COUNT, 0);
        rc("prescale_in_reset", `PTM_ADDR_PRESCALE_COUNT, 0);
        wr(`PTM_ADDR_TIMER_CONTROL, 32'h0);
        // wrap through ffff, channel 1 stops one step later
        wr(`PTM_ADDR_MATCH_VALUE0 + `PTM_ADDR_MATCH_STEP, 32'h1);
        wr(`PTM_ADDR_PRESCALE_LIMIT, 32'h0);
        wr(`PTM_ADDR_TIMER_COUNT, 32'hfffe);
        wr(`PTM_ADDR_MATCH_ACTION, 32'h28);
        wr(`PTM_ADDR_TIMER_CONTROL, 32'h1);
        repeat (20) @(posedge aclk);
        rc("count_after_wrap", `PTM_ADDR_TIMER_COUNT, 32'h1);
        rc("flags_match1", `PTM_ADDR_EVENT_FLAGS, 32'h2);
        pulse_capture();
        rc("capture_gated", `PTM_ADDR_EVENT_FLAGS, 32'h2);
        wr(`PTM_ADDR_CAPTURE_CONTROL, 32'h1);
        pulse_capture();
        rc("capture_flag", `PTM_ADDR_EVENT_FLAGS, 32'h12);
        test_done();
    end
endmodule
